// File: shared/ffl_pkg.sv
package ffl_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Widths
  localparam int ADDR_W = 16;
  localparam int RD_W   = 16;
  localparam int TRIM_W = 8;
  localparam int ID_W   = 4;
  localparam int FLAG_N = 8;
  localparam int DLY_W  = 16;
  localparam int TRIM_N = 18;

  ////////////////////////////////////////////////////////////////////////////
  // Timing: re-enable delay counts in ticks of one millisecond
  localparam int CLK_PERIOD_NS  = 100;
  localparam int TICK_PERIOD_NS = 1000000;
  localparam int TICK_CYCLES    = TICK_PERIOD_NS / CLK_PERIOD_NS;

  ////////////////////////////////////////////////////////////////////////////
  // Command codes and extended addresses
  localparam logic [ADDR_W-1:0] ADDR_UNLOCK_KEY   = 16'h00D6;
  localparam logic [ADDR_W-1:0] ADDR_MAIN_READING = 16'hFED0;
  localparam logic [ADDR_W-1:0] ADDR_CHA_READING  = 16'hFED1;
  localparam logic [ADDR_W-1:0] ADDR_CHB_READING  = 16'hFED2;

  // Every trim address under the password lock, in index order
  localparam logic [ADDR_W-1:0] TRIM_ADDRS [TRIM_N] = '{
    16'hFE10, 16'hFE11, 16'hFE12, 16'hFE13, 16'hFE14, 16'hFE15,
    16'hFE16, 16'hFE17, 16'hFE1C, 16'hFE1D, 16'hFE6E, 16'hFE73,
    16'hFE74, 16'hFE77, 16'hFE7C, 16'hFE7D, 16'hFE7E, 16'hFE7F};

  // Gain trim slots within the trim array
  localparam logic [4:0] IDX_CHA_GAIN  = 5'h00;
  localparam logic [4:0] IDX_CHB_GAIN  = 5'h01;
  localparam logic [4:0] IDX_MAIN_GAIN = 5'h0A;
  localparam logic [4:0] IDX_NONE      = 5'h1F;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values and key handling
  localparam logic [TRIM_W-1:0] KEY_FACTORY = 8'hFF;
  localparam logic [TRIM_W-1:0] TRIM_RESET  = 8'h80;
  localparam logic [1:0]        KEY_WRITES  = 2'h2;

  // Record layout in the nonvolatile word: {previous, current}
  localparam int CUR_LSB  = 0;
  localparam int PREV_LSB = ID_W;

  ////////////////////////////////////////////////////////////////////////////
  // Supply sequencer states
  typedef enum logic [5:0] {
    ST_OFF   = 6'b000001,
    ST_LOAD  = 6'b000010,
    ST_ON    = 6'b000100,
    ST_STORE = 6'b001000,
    ST_HOLD  = 6'b010000,
    ST_WAIT  = 6'b100000
  } state_t;

endpackage : ffl_pkg

// File: shared/trim_lock_if.sv
`timescale 1ns/10ps
interface trim_lock_if;
  logic                      key_wr;
  logic [ffl_pkg::TRIM_W-1:0] key_data;
  logic                      unlocked;

  // Register front end drives key writes
  modport owner (output key_wr, output key_data, input unlocked);
  // Lock keeper judges them
  modport keeper (input key_wr, input key_data, output unlocked);
endinterface : trim_lock_if

// File: verilog/trim_lock_keeper.sv
`timescale 1ns/10ps
module trim_lock_keeper (
  // Clock and reset
  input  wire logic    ref_clk,
  input  wire logic    arst_n,
  // Key writes in, unlock state out
  trim_lock_if.keeper  lk
);

  logic [1:0] cnt_q;
  logic [1:0] cnt_d;
  logic       unl_q;
  logic       unl_d;

  ////////////////////////////////////////////////////////////////////////////
  // Count matching key writes; any wrong key relocks at once
  always_comb begin
    cnt_d = cnt_q;
    unl_d = unl_q;
    if (lk.key_wr) begin
      if (lk.key_data == ffl_pkg::KEY_FACTORY) begin // RULE8
        if (cnt_q != ffl_pkg::KEY_WRITES) begin
          cnt_d = cnt_q + 2'h1;
        end
        if (cnt_q + 2'h1 >= ffl_pkg::KEY_WRITES) begin
          unl_d = 1'b1; // RULE7
        end
      end else begin
        cnt_d = 2'h0;
        unl_d = 1'b0;
      end
    end
  end

  // Register only
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q <= 2'h0;
      unl_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      unl_q <= unl_d;
    end
  end

  assign lk.unlocked = unl_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  property p_two_keys;
    @(posedge ref_clk) disable iff (!arst_n)
    (lk.key_wr && lk.key_data == ffl_pkg::KEY_FACTORY && !unl_q) ##1
    (lk.key_wr && lk.key_data == ffl_pkg::KEY_FACTORY) |=> unl_q;
  endproperty
  a_two_keys: assert property (p_two_keys) else $error("two keys left lock shut"); // RULE7

  property p_one_key;
    @(posedge ref_clk) disable iff (!arst_n)
    (cnt_q == 2'h0 && lk.key_wr && lk.key_data == ffl_pkg::KEY_FACTORY) |=> !unl_q;
  endproperty
  a_one_key: assert property (p_one_key) else $error("one key write unlocked"); // RULE7

  property p_bad_key;
    @(posedge ref_clk) disable iff (!arst_n)
    (lk.key_wr && lk.key_data != ffl_pkg::KEY_FACTORY) |=> !unl_q;
  endproperty
  a_bad_key: assert property (p_bad_key) else $error("wrong key unlocked"); // RULE8

endmodule : trim_lock_keeper

// File: verilog/first_fault_log_trim_lock.sv
// What this block does
// RULE1 - Dropping the power-on request turns the supply off.
// RULE2 - At power-on the stored first-fault ID is read back into both record slots.
// RULE3 - A shutdown fault shifts current to previous, records the new ID, then saves it.
// RULE4 - A fault arriving while the supply is already off changes neither record copy.
// RULE5 - Clearing a fault leaves the record alone and other faults still hold the supply off.
// RULE6 - Once all faults clear the supply restarts after the delay with the record unchanged.
// RULE7 - Trim registers stay locked until the key is written correctly twice to command D6.
// RULE8 - The key as shipped is all ones.
// RULE9 - The lock covers every trim address from FE10 through FE7F listed in the map.
// RULE10 - Main and both channel sense inputs each have a gain trim of their own.
// RULE11 - The three sense readings are read back at FED0, FED1 and FED2.
// RULE12 - The host applies 1 V and tunes each gain trim until its reading is 2560. The testbench tunes only the main gain trim.
// RULE13 - Trim writes made while locked are dropped.
`timescale 1ns/10ps
module first_fault_log_trim_lock #(
  parameter int TICK_CYCLES = ffl_pkg::TICK_CYCLES,
  parameter int FLAG_N      = ffl_pkg::FLAG_N
) (
  // Clock and reset
  input  wire logic                         ref_clk,
  input  wire logic                         arst_n,
  // Supply control pins and fault sources
  input  wire logic                         power_on_request,
  input  wire logic [FLAG_N-1:0]            fault_flags,
  input  wire logic [ffl_pkg::DLY_W-1:0]    reenable_delay,
  output logic                              supply_on,
  // Register port
  input  wire logic                         reg_wr,
  input  wire logic                         reg_rd,
  input  wire logic [ffl_pkg::ADDR_W-1:0]   reg_addr,
  input  wire logic [ffl_pkg::TRIM_W-1:0]   reg_wdata,
  output logic [ffl_pkg::RD_W-1:0]          reg_rdata,
  output logic                              reg_rvalid,
  // Converter readings
  input  wire logic [ffl_pkg::RD_W-1:0]     main_sense_value,
  input  wire logic [ffl_pkg::RD_W-1:0]     chan_a_sense_value,
  input  wire logic [ffl_pkg::RD_W-1:0]     chan_b_sense_value,
  // Nonvolatile record port
  output logic                              nvm_rd_req,
  output logic                              nvm_wr_req,
  output logic [2*ffl_pkg::ID_W-1:0]        nvm_wdata,
  input  wire logic [2*ffl_pkg::ID_W-1:0]   nvm_rdata,
  input  wire logic                         nvm_ack,
  // Record and trim state
  output logic [ffl_pkg::ID_W-1:0]          fault_cur_id,
  output logic [ffl_pkg::ID_W-1:0]          fault_prev_id,
  output logic [ffl_pkg::TRIM_W-1:0]        main_gain_trim,
  output logic [ffl_pkg::TRIM_W-1:0]        chan_a_gain_trim,
  output logic [ffl_pkg::TRIM_W-1:0]        chan_b_gain_trim,
  output logic                              trim_unlocked
);

  localparam int IW = ffl_pkg::ID_W;
  localparam int TW = ffl_pkg::TRIM_W;
  localparam int TC = (TICK_CYCLES < 1) ? 1 : TICK_CYCLES;

  ////////////////////////////////////////////////////////////////////////////
  // Functions

  // Lowest set flag wins; its ID is the bit index plus one, zero if none
  function automatic logic [IW-1:0] first_flag(input logic [FLAG_N-1:0] f);
    logic [IW-1:0] id;
    id = '0;
    for (int i = FLAG_N - 1; i >= 0; i--) begin
      if (f[i]) begin
        id = IW'(i + 1);
      end
    end
    return id;
  endfunction : first_flag

  // Map an address to its trim slot, IDX_NONE when it is no trim
  function automatic logic [4:0] trim_index(input logic [ffl_pkg::ADDR_W-1:0] a);
    logic [4:0] idx;
    idx = ffl_pkg::IDX_NONE;
    for (int i = 0; i < ffl_pkg::TRIM_N; i++) begin
      if (a == ffl_pkg::TRIM_ADDRS[i]) begin
        idx = 5'(i);
      end
    end
    return idx;
  endfunction : trim_index

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; only the second stage feeds logic
  logic              pon_m;
  logic              pon_s;
  logic [FLAG_N-1:0] flt_m;
  logic [FLAG_N-1:0] flt_s;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      pon_m <= 1'b0;
      pon_s <= 1'b0;
      flt_m <= '0;
      flt_s <= '0;
    end else begin
      pon_m <= power_on_request;
      pon_s <= pon_m;
      flt_m <= fault_flags;
      flt_s <= flt_m;
    end
  end

  logic          any_fault;
  logic [IW-1:0] new_id;

  assign any_fault = |flt_s;
  assign new_id    = first_flag(flt_s);

  ////////////////////////////////////////////////////////////////////////////
  // Millisecond tick divider, free running so the delay unit is stable
  logic [31:0] tick_cnt_q;
  logic [31:0] tick_cnt_d;
  logic        tick;

  always_comb begin
    tick       = (tick_cnt_q == 32'(TC - 1));
    tick_cnt_d = tick ? 32'h0 : tick_cnt_q + 32'h1;
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      tick_cnt_q <= 32'h0;
    end else begin
      tick_cnt_q <= tick_cnt_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Supply sequencer and first-fault record
  ffl_pkg::state_t          st_q;
  ffl_pkg::state_t          st_d;
  logic [IW-1:0]            cur_q;
  logic [IW-1:0]            cur_d;
  logic [IW-1:0]            prev_q;
  logic [IW-1:0]            prev_d;
  logic [ffl_pkg::DLY_W-1:0] dly_q;
  logic [ffl_pkg::DLY_W-1:0] dly_d;
  logic                     on_d;
  logic                     rdq_d;
  logic                     wrq_d;
  logic [2*IW-1:0]          wdat_d;

  always_comb begin
    st_d   = st_q;
    cur_d  = cur_q;
    prev_d = prev_q;
    dly_d  = dly_q;
    rdq_d  = 1'b0;
    wrq_d  = 1'b0;
    wdat_d = nvm_wdata;
    if (tick && dly_q != '0) begin
      dly_d = dly_q - {{(ffl_pkg::DLY_W-1){1'b0}}, 1'b1};
    end
    case (st_q)
      ffl_pkg::ST_OFF: begin
        if (pon_s) begin
          st_d  = ffl_pkg::ST_LOAD;
          rdq_d = 1'b1;
        end
      end
      ffl_pkg::ST_LOAD: begin
        if (nvm_ack) begin
          cur_d  = nvm_rdata[ffl_pkg::CUR_LSB +: IW]; // RULE2
          prev_d = nvm_rdata[ffl_pkg::CUR_LSB +: IW]; // RULE2
          st_d   = ffl_pkg::ST_ON;
        end else begin
          rdq_d = 1'b1;
        end
      end
      ffl_pkg::ST_ON: begin
        if (any_fault) begin
          prev_d = cur_q; // RULE3
          cur_d  = new_id; // RULE3
          wdat_d = {cur_q, new_id}; // RULE3
          wrq_d  = 1'b1;
          st_d   = ffl_pkg::ST_STORE;
        end
      end
      ffl_pkg::ST_STORE: begin
        // Finish the save even if the request drops meanwhile
        if (nvm_ack) begin
          st_d = ffl_pkg::ST_HOLD;
        end else begin
          wrq_d = 1'b1;
        end
      end
      ffl_pkg::ST_HOLD: begin
        if (!any_fault) begin // RULE5
          st_d  = ffl_pkg::ST_WAIT;
          dly_d = reenable_delay;
        end
      end
      ffl_pkg::ST_WAIT: begin
        if (any_fault) begin
          st_d = ffl_pkg::ST_HOLD; // RULE4
        end else if (dly_q == '0) begin
          st_d = ffl_pkg::ST_ON; // RULE6
        end
      end
      default: begin
        st_d = ffl_pkg::ST_OFF;
      end
    endcase
    if (!pon_s && st_q != ffl_pkg::ST_STORE && st_d != ffl_pkg::ST_STORE) begin
      st_d  = ffl_pkg::ST_OFF; // RULE1
      rdq_d = 1'b0;
    end
    on_d = (st_d == ffl_pkg::ST_ON);
  end

  // Register only
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_q          <= ffl_pkg::ST_OFF;
      cur_q         <= '0;
      prev_q        <= '0;
      dly_q         <= '0;
      supply_on     <= 1'b0;
      nvm_rd_req    <= 1'b0;
      nvm_wr_req    <= 1'b0;
      nvm_wdata     <= '0;
    end else begin
      st_q          <= st_d;
      cur_q         <= cur_d;
      prev_q        <= prev_d;
      dly_q         <= dly_d;
      supply_on     <= on_d;
      nvm_rd_req    <= rdq_d;
      nvm_wr_req    <= wrq_d;
      nvm_wdata     <= wdat_d;
    end
  end

  assign fault_cur_id  = cur_q;
  assign fault_prev_id = prev_q;

  ////////////////////////////////////////////////////////////////////////////
  // Trim lock keeper
  trim_lock_if lk ();

  assign lk.key_wr   = reg_wr && (reg_addr == ffl_pkg::ADDR_UNLOCK_KEY);
  assign lk.key_data = reg_wdata;
  assign trim_unlocked = lk.unlocked;

  trim_lock_keeper u_lock (
    .ref_clk (ref_clk),
    .arst_n  (arst_n),
    .lk      (lk.keeper)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Trim array and read-back; the key itself reads as zero
  logic [TW-1:0]           trim_q [ffl_pkg::TRIM_N];
  logic [TW-1:0]           trim_d [ffl_pkg::TRIM_N];
  logic [ffl_pkg::RD_W-1:0] rdata_d;
  logic [4:0]              w_idx;
  logic [4:0]              r_idx;

  always_comb begin
    w_idx  = trim_index(reg_addr);
    r_idx  = w_idx;
    trim_d = trim_q;
    // Locked writes are simply dropped, no error shows
    if (reg_wr && lk.unlocked && w_idx != ffl_pkg::IDX_NONE) begin // RULE9 RULE13
      trim_d[w_idx] = reg_wdata; // RULE10
    end
    rdata_d = '0;
    if (r_idx != ffl_pkg::IDX_NONE) begin
      rdata_d = {8'h00, trim_q[r_idx]};
    end else if (reg_addr == ffl_pkg::ADDR_MAIN_READING) begin
      rdata_d = main_sense_value; // RULE11
    end else if (reg_addr == ffl_pkg::ADDR_CHA_READING) begin
      rdata_d = chan_a_sense_value; // RULE11
    end else if (reg_addr == ffl_pkg::ADDR_CHB_READING) begin
      rdata_d = chan_b_sense_value; // RULE11
    end
  end

  // Register only
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < ffl_pkg::TRIM_N; i++) begin
        trim_q[i] <= ffl_pkg::TRIM_RESET;
      end
      reg_rdata  <= '0;
      reg_rvalid <= 1'b0;
    end else begin
      trim_q     <= trim_d;
      reg_rdata  <= reg_rd ? rdata_d : '0;
      reg_rvalid <= reg_rd;
    end
  end

  assign main_gain_trim   = trim_q[ffl_pkg::IDX_MAIN_GAIN];
  assign chan_a_gain_trim = trim_q[ffl_pkg::IDX_CHA_GAIN];
  assign chan_b_gain_trim = trim_q[ffl_pkg::IDX_CHB_GAIN];

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);

  property p_off;
    !pon_s |=> !supply_on;
  endproperty
  a_off: assert property (p_off) else $error("supply on without request"); // RULE1

  property p_load;
    (st_q == ffl_pkg::ST_LOAD && nvm_ack && pon_s) |=>
      (cur_q == $past(nvm_rdata[IW-1:0]) && prev_q == cur_q && supply_on);
  endproperty
  a_load: assert property (p_load) else $error("record not loaded"); // RULE2

  property p_shift;
    (st_q == ffl_pkg::ST_ON && any_fault && pon_s) |=>
      (cur_q == $past(new_id) && prev_q == $past(cur_q) && nvm_wr_req
       && nvm_wdata == {prev_q, cur_q} && !supply_on);
  endproperty
  a_shift: assert property (p_shift) else $error("shutdown record wrong"); // RULE3

  property p_save_after;
    $rose(nvm_wr_req) |-> ($past(st_q) == ffl_pkg::ST_ON && nvm_wdata == {prev_q, cur_q});
  endproperty
  a_save_after: assert property (p_save_after) else $error("save without update"); // RULE3

  property p_off_fault;
    (st_q == ffl_pkg::ST_HOLD || st_q == ffl_pkg::ST_WAIT) |=>
      ($stable(cur_q) && $stable(prev_q) && !nvm_wr_req);
  endproperty
  a_off_fault: assert property (p_off_fault) else $error("record moved while off"); // RULE4

  property p_held;
    any_fault |=> !supply_on;
  endproperty
  a_held: assert property (p_held) else $error("supply on under fault"); // RULE5

  property p_wait;
    (st_q == ffl_pkg::ST_WAIT && dly_q != '0) |=> !supply_on;
  endproperty
  a_wait: assert property (p_wait) else $error("restart before delay"); // RULE6

  property p_restart;
    (st_q == ffl_pkg::ST_WAIT && st_d == ffl_pkg::ST_ON) |=>
      (supply_on && $stable(cur_q) && $stable(prev_q));
  endproperty
  a_restart: assert property (p_restart) else $error("restart bad"); // RULE6

  property p_locked;
    (reg_wr && !lk.unlocked) |=>
      ($stable(main_gain_trim) && $stable(chan_a_gain_trim) && $stable(chan_b_gain_trim));
  endproperty
  a_locked: assert property (p_locked) else $error("locked trim written"); // RULE13

  property p_gain_wr;
    (reg_wr && lk.unlocked && reg_addr == ffl_pkg::TRIM_ADDRS[ffl_pkg::IDX_MAIN_GAIN]) |=>
      main_gain_trim == $past(reg_wdata);
  endproperty
  a_gain_wr: assert property (p_gain_wr) else $error("main gain not written"); // RULE10

  property p_read;
    (reg_rd && reg_addr == ffl_pkg::ADDR_CHB_READING) |=>
      (reg_rvalid && reg_rdata == $past(chan_b_sense_value));
  endproperty
  a_read: assert property (p_read) else $error("reading read-back wrong"); // RULE11

endmodule : first_fault_log_trim_lock

// File: dv/nvm_model.sv
`timescale 1ns/10ps
module nvm_model #(
  parameter logic [7:0] INIT = 8'h52
) (
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       arst_n,
  // Requests from the record keeper
  input  wire logic       rd_req,
  input  wire logic       wr_req,
  input  wire logic [7:0] wdata,
  input  wire logic [7:0] lat,
  // Answers and stored word
  output logic      [7:0] rdata,
  output logic            ack,
  output logic      [7:0] stored,
  output logic      [7:0] wr_cnt
);
  logic [7:0] cnt_q;
  logic       done_q;

  // Word only valid in the ack cycle; inverse elsewhere so stale samples show up
  assign rdata = ack ? stored : ~stored;

  // One ack per request after lat cycles, then wait for the request to drop
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q  <= 8'h00;
      done_q <= 1'b0;
      ack    <= 1'b0;
      stored <= INIT;
      wr_cnt <= 8'h00;
    end else begin
      ack <= 1'b0;
      if ((rd_req || wr_req) && !done_q) begin
        if (cnt_q == lat) begin
          ack    <= 1'b1;
          done_q <= 1'b1;
          cnt_q  <= 8'h00;
          if (wr_req) begin
            stored <= wdata;
            wr_cnt <= wr_cnt + 8'h01;
          end
        end else begin
          cnt_q <= cnt_q + 8'h01;
        end
      end else if (!(rd_req || wr_req)) begin
        done_q <= 1'b0;
        cnt_q  <= 8'h00;
      end
    end
  end
endmodule : nvm_model

// File: dv/first_fault_log_trim_lock_tb.sv
`timescale 1ns/10ps
module first_fault_log_trim_lock_tb;
  // Short tick keeps the restart delay a few cycles long
  localparam int TICKS = 4;

  logic        ref_clk, arst_n, power_on_request, supply_on, trim_unlocked;
  logic        reg_wr, reg_rd, reg_rvalid, nvm_rd_req, nvm_wr_req, nvm_ack;
  logic [7:0]  fault_flags, reg_wdata, nvm_wdata, nvm_rdata, nvm_lat, nvm_stored, nvm_wr_cnt;
  logic [7:0]  main_gain_trim, chan_a_gain_trim, chan_b_gain_trim;
  logic [15:0] reenable_delay, reg_addr, reg_rdata;
  logic [15:0] main_sense_value, chan_a_sense_value, chan_b_sense_value;
  logic [3:0]  fault_cur_id, fault_prev_id;
  int          error_cnt;
  int          total_checks;

  ////////////////////////////////////////////////////////////////////////////
  first_fault_log_trim_lock #(.TICK_CYCLES(TICKS)) u_dut (
    .ref_clk(ref_clk), .arst_n(arst_n), .power_on_request(power_on_request),
    .fault_flags(fault_flags), .reenable_delay(reenable_delay), .supply_on(supply_on),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .main_sense_value(main_sense_value),
    .chan_a_sense_value(chan_a_sense_value), .chan_b_sense_value(chan_b_sense_value),
    .nvm_rd_req(nvm_rd_req), .nvm_wr_req(nvm_wr_req), .nvm_wdata(nvm_wdata),
    .nvm_rdata(nvm_rdata), .nvm_ack(nvm_ack), .fault_cur_id(fault_cur_id),
    .fault_prev_id(fault_prev_id), .main_gain_trim(main_gain_trim),
    .chan_a_gain_trim(chan_a_gain_trim), .chan_b_gain_trim(chan_b_gain_trim),
    .trim_unlocked(trim_unlocked));

  nvm_model #(.INIT(8'h52)) u_nvm (
    .ref_clk(ref_clk), .arst_n(arst_n), .rd_req(nvm_rd_req), .wr_req(nvm_wr_req),
    .wdata(nvm_wdata), .lat(nvm_lat), .rdata(nvm_rdata), .ack(nvm_ack),
    .stored(nvm_stored), .wr_cnt(nvm_wr_cnt));

  // Converter stand-in: reading tracks the gain trim, 1 V reads 0xA00 at trim 0xA0
  assign main_sense_value = {4'h0, main_gain_trim, 4'h0};

  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic end_of_test();
    if (error_cnt == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : end_of_test

  task automatic idle(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : idle

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    #1;
  endtask : wr

  task automatic rd(input logic [15:0] a, output logic [15:0] d);
    @(posedge ref_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    check("reg_rvalid", 16'(reg_rvalid), 16'h0001);
    d = reg_rdata;
  endtask : rd

  // Bounded wait for the supply to reach a level
  task automatic wait_supply(input logic lvl, input int lim);
    int n;
    n = 0;
    while (supply_on !== lvl && n < lim) begin
      idle(1);
      n++;
    end
    check("supply_on", 16'(supply_on), 16'(lvl));
  endtask : wait_supply

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_locked();
    logic [15:0] d;
    check("trim_unlocked", 16'(trim_unlocked), 16'h0000);
    for (int i = 0; i < ffl_pkg::TRIM_N; i++) begin
      wr(ffl_pkg::TRIM_ADDRS[i], 8'h3C);
      rd(ffl_pkg::TRIM_ADDRS[i], d);
      check("locked trim", d, 16'h0080);
    end
  endtask : t_locked

  task automatic t_unlock();
    logic [15:0] d;
    wr(16'h00D6, 8'hFF);
    check("one key", 16'(trim_unlocked), 16'h0000);
    wr(16'h00D6, 8'h5A);
    wr(16'h00D6, 8'hFF);
    check("count restart", 16'(trim_unlocked), 16'h0000);
    wr(16'h00D6, 8'hFF);
    check("two keys", 16'(trim_unlocked), 16'h0001);
    rd(16'h00D6, d);
    check("key read", d, 16'h0000);
    for (int i = 0; i < ffl_pkg::TRIM_N; i++) wr(ffl_pkg::TRIM_ADDRS[i], 8'(8'h40 + i));
    for (int i = 0; i < ffl_pkg::TRIM_N; i++) begin
      rd(ffl_pkg::TRIM_ADDRS[i], d);
      check("open trim", d, 16'(8'h40 + i));
    end
    check("chan_a gain", 16'(chan_a_gain_trim), 16'h0040);
    check("chan_b gain", 16'(chan_b_gain_trim), 16'h0041);
    check("main gain", 16'(main_gain_trim), 16'h004A);
  endtask : t_unlock

  task automatic t_readings();
    logic [15:0] d;
    @(posedge ref_clk);
    chan_a_sense_value <= 16'h0A5C;
    chan_b_sense_value <= 16'h0F31;
    rd(16'hFED0, d);
    check("main reading", d, 16'h04A0);
    rd(16'hFED1, d);
    check("chan_a reading", d, 16'h0A5C);
    rd(16'hFED2, d);
    check("chan_b reading", d, 16'h0F31);
    rd(16'hFE00, d);
    check("unmapped read", d, 16'h0000);
  endtask : t_readings

  // Host sweeps the main gain trim until 1 V reads 0xA00
  task automatic t_calibrate();
    logic [15:0] d;
    for (int v = 8'h90; v < 8'hB0; v++) begin
      wr(16'hFE6E, 8'(v));
      rd(16'hFED0, d);
      if (d === 16'h0A00) break;
    end
    check("calibrated trim", 16'(main_gain_trim), 16'h00A0);
    wr(16'h00D6, 8'h00);
    check("relock", 16'(trim_unlocked), 16'h0000);
    wr(16'hFE10, 8'h99);
    check("relocked write", 16'(chan_a_gain_trim), 16'h0040);
  endtask : t_calibrate

  task automatic t_fault_log();
    @(posedge ref_clk);
    nvm_lat          <= 8'h03;
    reenable_delay   <= 16'h0003;
    power_on_request <= 1'b1;
    wait_supply(1'b1, 60);
    check("load cur", 16'(fault_cur_id), 16'h0002);
    check("load prev", 16'(fault_prev_id), 16'h0002);
    @(posedge ref_clk);
    fault_flags <= 8'h04;
    wait_supply(1'b0, 10);
    check("trip cur", 16'(fault_cur_id), 16'h0003);
    check("trip prev", 16'(fault_prev_id), 16'h0002);
    check("nvm before save", 16'(nvm_stored), 16'h0052);
    idle(12);
    check("nvm saved", 16'(nvm_stored), 16'h0023);
    // Second fault while already off must not touch either copy
    @(posedge ref_clk);
    fault_flags <= 8'h24;
    idle(12);
    check("late cur", 16'(fault_cur_id), 16'h0003);
    check("late nvm writes", 16'(nvm_wr_cnt), 16'h0001);
    @(posedge ref_clk);
    fault_flags <= 8'h20;
    idle(30);
    check("held off", 16'(supply_on), 16'h0000);
    check("clear prev", 16'(fault_prev_id), 16'h0002);
    @(posedge ref_clk);
    fault_flags <= 8'h00;
    idle(6);
    check("delay pending", 16'(supply_on), 16'h0000);
    wait_supply(1'b1, 40);
    check("restart cur", 16'(fault_cur_id), 16'h0003);
    check("restart writes", 16'(nvm_wr_cnt), 16'h0001);
    @(posedge ref_clk);
    fault_flags <= 8'h20;
    wait_supply(1'b0, 10);
    check("second cur", 16'(fault_cur_id), 16'h0006);
    check("second prev", 16'(fault_prev_id), 16'h0003);
    idle(12);
    check("second save", 16'(nvm_stored), 16'h0036);
    @(posedge ref_clk);
    fault_flags    <= 8'h00;
    reenable_delay <= 16'h0000;
    wait_supply(1'b1, 20);
    @(posedge ref_clk);
    power_on_request <= 1'b0;
    wait_supply(1'b0, 6);
    // Slow memory on the next power-up
    @(posedge ref_clk);
    nvm_lat          <= 8'h0A;
    power_on_request <= 1'b1;
    wait_supply(1'b1, 80);
    check("reload cur", 16'(fault_cur_id), 16'h0006);
    check("reload prev", 16'(fault_prev_id), 16'h0006);
  endtask : t_fault_log

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    error_cnt = 0;
    total_checks = 0;
    arst_n = 1'b0;
    power_on_request = 1'b0;
    fault_flags = 8'h00;
    reenable_delay = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 16'h0000;
    reg_wdata = 8'h00;
    chan_a_sense_value = 16'h0000;
    chan_b_sense_value = 16'h0000;
    nvm_lat = 8'h03;
    repeat (3) @(posedge ref_clk);
    arst_n <= 1'b1;
    idle(1);
    t_locked();
    t_unlock();
    t_readings();
    t_calibrate();
    t_fault_log();
    end_of_test();
  end

  // Watchdog: the whole run needs well under 3000 cycles
  initial begin
    #2000000;
    error_cnt++;
    end_of_test();
  end
endmodule : first_fault_log_trim_lock_tb
